// ---- pkg/stm_log_if.sv ----
// Write and read path between the monitor and its event-log memory.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
interface stm_log_if #(parameter int AW = 3, parameter int DW = 13);
  logic we;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;
  logic [AW-1:0] raddr;
  logic [DW-1:0] rdata;
  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// ---- pkg/stm_pkg.sv ----
// Constants of the supply threshold monitor: command codes, reset values,
// status bit positions and tick timing.
// Assumes a 50 MHz core clock.
package stm_pkg;
  // ----------------------------------------
  // Command codes and threshold reset values
  // ----------------------------------------
  localparam logic [7:0] CMD_OUT_UV_WARN = 8'h43;
  localparam logic [7:0] CMD_IN_OV_FLT = 8'h55;
  localparam logic [7:0] CMD_IN_OV_WARN = 8'h57;
  localparam logic [7:0] CMD_IN_UV_FLT = 8'h59;
  localparam logic [7:0] CMD_STATUS_WORD = 8'h79;
  localparam logic [15:0] RST_OUT_UV_WARN = 16'h0095;
  localparam logic [15:0] RST_IN_OV_FLT = 16'h000e;
  localparam logic [15:0] RST_IN_OV_WARN = 16'h00a5;
  localparam logic [15:0] RST_IN_UV_FLT = 16'h008d;
  // ----------------------------------------
  // Status bit positions and alert mask bits
  // ----------------------------------------
  localparam int SB_SWITCH_OFF = 6;
  localparam int SB_IN_LOW = 3;
  localparam int SB_OTHER = 0;
  localparam int SW_OUT = 7;
  localparam int SW_IN = 5;
  localparam int SW_PNG = 3;
  localparam int SW_OTHER = 0;
  localparam int SO_LOW_WARN = 5;
  localparam int SI_HIGH_FLT = 7;
  localparam int SI_HIGH_WARN = 5;
  localparam int SI_LOW_FLT = 3;
  localparam int M2_PNG = 4;
  localparam int MASK_IN = 0;
  localparam int MASK_OUT = 1;
  localparam int MASK_PNG = 2;
  // ----------------------------------------
  // Hysteresis, event log and tick timing
  // ----------------------------------------
  localparam int HYST_MV = 250;
  localparam int FULL_SCALE_MV = 19420;
  localparam int FULL_CODE = 255;
  localparam int HYST_CODES = (HYST_MV * FULL_CODE + FULL_SCALE_MV - 1) / FULL_SCALE_MV;
  localparam int LOG_AW = 3;
  localparam int LOG_DW = 13;
  localparam int LOG_DEPTH = 7;
  localparam logic [2:0] LOG_LAST_PTR = 3'h6;
  localparam logic [7:0] EVT_IN_HIGH_WARN = 8'h05; // Arbitrary identifier value.
  localparam int CLK_FREQ_MHZ = 50;
  localparam int TICK_TIME_US = 1000;
  localparam int TICK_CYCLES_DEF = TICK_TIME_US * CLK_FREQ_MHZ;
endpackage

// ---- sim/stm_afe_model.sv ----
// Behavioural comparator front end of the overvoltage trip.
// Assumes the input level is a code on the same scale as the DAC code.
`timescale 1ns/10ps
module stm_afe_model (
  input logic [3:0] in_level,
  input logic [3:0] dac_code,
  output logic above_rise,
  output logic below_fall
);
  // One DAC step stands in for the hysteresis, so the window between trips is never empty.
  assign above_rise = (in_level > dac_code);
  assign below_fall = (in_level < dac_code);
endmodule // stm_afe_model

// ---- sim/testbench.sv ----
// Self-checking bench of the supply threshold monitor.
// Assumes the comparator model of stm_afe_model and a short tick count.
`timescale 1ns/10ps
module testbench;
  import stm_pkg::*;
  // ----------------------------------------
  // Signals and expected bytes
  // ----------------------------------------
  logic clk, reset_n, cmd_valid, cmd_write, clear_faults, pin4, pin1;
  logic [7:0] cmd_code, vin_adc, vout_adc, sb, sw, sv, si, m2, ptr_tmr;
  logic [15:0] cmd_wdata, rd, cmd_rdata_ff;
  logic [2:0] alert_mask, log_rd_addr;
  logic [3:0] ov_level, dac;
  logic rise, fall, ack, sw_on, pg, alert_n;
  logic [LOG_DW-1:0] log_data;
  int errors = 0;
  int n_compared = 0;
  int cycles = 0;
  logic [7:0] codes [4] = '{CMD_OUT_UV_WARN, CMD_IN_OV_FLT, CMD_IN_OV_WARN, CMD_IN_UV_FLT};
  logic [15:0] rsts [4] = '{RST_OUT_UV_WARN, RST_IN_OV_FLT, RST_IN_OV_WARN, RST_IN_UV_FLT};
  localparam logic [7:0] WH_FLT = (8'h1 << SW_OUT) | (8'h1 << SW_IN) | (8'h1 << SW_PNG)
    | (8'h1 << SW_OTHER);
  localparam logic [7:0] SB_OV = (8'h1 << SB_SWITCH_OFF) | (8'h1 << SB_OTHER);
  localparam logic [7:0] SB_UV = SB_OV | (8'h1 << SB_IN_LOW);
  localparam logic [7:0] LOWW = 8'h1 << SO_LOW_WARN;
  localparam logic [7:0] PNG = 8'h1 << M2_PNG;
  localparam logic [7:0] OTH = 8'h1 << SB_OTHER;
  // Arbitrary unlock code; the monitor never locks writes, so it must simply ignore it.
  localparam logic [7:0] CMD_WRITE_UNLOCK = 8'hfc;

  stm_monitor #(.TICK_CYCLES(8)) i_dut (
    .clk(clk), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_ack_ff(ack), .cmd_rdata_ff(cmd_rdata_ff),
    .vin_adc(vin_adc), .vout_adc(vout_adc), .ov_above_rise(rise), .ov_below_fall(fall),
    .in_ov_dac_code_ff(dac), .clear_faults(clear_faults), .alert_mask(alert_mask),
    .general_pin_four_is_alert(pin4), .general_pin_one_is_pg(pin1),
    .log_rd_addr(log_rd_addr), .log_rd_data_ff(log_data), .switch_on_ff(sw_on),
    .power_good_pin_ff(pg), .bus_alert_n_ff(alert_n), .status_byte_ff(sb),
    .status_word_hi_ff(sw), .status_vout_ff(sv), .status_input_ff(si),
    .vendor_status_reg_two_ff(m2), .event_log_pointer_timer_ff(ptr_tmr)
  );

  stm_afe_model i_afe (.in_level(ov_level), .dac_code(dac), .above_rise(rise), .below_fall(fall));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic summarize;
    $display("errors=%0d n_compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // The port takes one-cycle pulses, so the request drops right after its taking edge.
  task automatic cmd(input logic wr, input logic [7:0] code, input logic [15:0] wd);
    int k;
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_write <= wr;
    cmd_code <= code;
    cmd_wdata <= wd;
    @(posedge clk);
    cmd_valid <= 1'b0;
    k = 0;
    #1;
    while (ack !== 1'b1 && k < 4)
    begin
      @(posedge clk);
      #1;
      k++;
    end
    chk(ack, 1'b1);
    rd = cmd_rdata_ff;
  endtask

  task automatic st(input logic [7:0] b, w, v, i, m);
    chk(sb, b);
    chk(sw, w);
    chk(sv, v);
    chk(si, i);
    chk(m2, m);
  endtask

  task automatic clr;
    @(posedge clk);
    clear_faults <= 1'b1;
    @(posedge clk);
    clear_faults <= 1'b0;
    step(2);
  endtask

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Cut a hang short well beyond the hundred or so cycles the sequence needs.
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      errors++;
      summarize;
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    reset_n = 1'b0;
    {cmd_valid, cmd_write, clear_faults} = 3'h0;
    {pin4, pin1} = 2'h3;
    cmd_code = 8'h00;
    cmd_wdata = 16'h0000;
    vin_adc = 8'ha0;
    vout_adc = 8'hc0;
    ov_level = 4'h0;
    alert_mask = 3'h0;
    log_rd_addr = 3'h0;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    step(2);
    chk(dac, RST_IN_OV_FLT[3:0]);
    chk({sw_on, pg, alert_n}, 3'h7);
    cmd(1'b1, CMD_WRITE_UNLOCK, 16'h0000);
    for (int i = 0; i < 4; i++)
    begin
      cmd(1'b0, codes[i], 16'h0000);
      chk(rd, rsts[i]);
    end
    // Write and read back to back; the low byte stays above the input so no warning fires.
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd_write <= 1'b1;
    cmd_code <= CMD_IN_OV_WARN;
    cmd_wdata <= 16'h12c4;
    @(posedge clk);
    cmd_write <= 1'b0;
    @(posedge clk);
    cmd_valid <= 1'b0;
    #1;
    chk(ack, 1'b1);
    chk(cmd_rdata_ff, 16'h12c4);
    cmd(1'b1, CMD_IN_OV_WARN, 16'h00b0);
    cmd(1'b0, CMD_IN_OV_WARN, 16'h0000);
    chk(rd, 16'h00b0);
    cmd(1'b0, 8'h00, 16'hffff);
    chk(rd, 16'h0000);
    // Input high warning, first at the threshold, then above it with the input alert masked.
    @(posedge clk);
    vin_adc <= 8'hb0;
    step(2);
    chk(si, 8'h00);
    @(posedge clk);
    vin_adc <= 8'hb8;
    alert_mask <= 3'h1 << MASK_IN;
    step(2);
    st(OTH, 8'h1 << SW_IN, 8'h00, 8'h1 << SI_HIGH_WARN, 8'h00);
    chk(alert_n, 1'b1);
    chk(ptr_tmr, 8'h20);
    chk(log_data[LOG_DW-1:5], EVT_IN_HIGH_WARN);
    @(posedge clk);
    alert_mask <= 3'h0;
    step(2);
    chk(alert_n, 1'b0);
    @(posedge clk);
    pin4 <= 1'b0;
    step(2);
    chk(alert_n, 1'b1);
    @(posedge clk);
    pin4 <= 1'b1;
    step(2);
    chk(alert_n, 1'b0);
    clr;
    chk(si, 8'h1 << SI_HIGH_WARN);
    chk(ptr_tmr, 8'h00);
    @(posedge clk);
    vin_adc <= 8'ha0;
    step(2);
    chk(alert_n, 1'b0);
    clr;
    st(8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
    chk(alert_n, 1'b1);
    // Output low warning, the threshold itself does not count as below.
    @(posedge clk);
    vout_adc <= 8'h95;
    step(2);
    chk(sv, 8'h00);
    @(posedge clk);
    vout_adc <= 8'h90;
    step(2);
    st(OTH, 8'h1 << SW_OUT, LOWW, 8'h00, 8'h00);
    chk(alert_n, 1'b0);
    @(posedge clk);
    vout_adc <= 8'hc0;
    step(2);
    chk(sv, LOWW);
    clr;
    st(8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
    chk(alert_n, 1'b1);
    // Input low fault and its recovery past the hysteresis band.
    @(posedge clk);
    vin_adc <= 8'h80;
    step(2);
    st(SB_UV, WH_FLT, LOWW, 8'h1 << SI_LOW_FLT, PNG);
    chk({sw_on, alert_n}, 2'h0);
    chk(pg, 1'b0);
    cmd(1'b0, CMD_STATUS_WORD, 16'h0000);
    chk(rd, {WH_FLT, SB_UV});
    @(posedge clk);
    vin_adc <= RST_IN_UV_FLT[7:0] + 8'(HYST_CODES);
    step(2);
    chk(sw_on, 1'b0);
    @(posedge clk);
    vin_adc <= RST_IN_UV_FLT[7:0] + 8'(HYST_CODES) + 8'h01;
    step(2);
    chk({sw_on, pg}, 2'h3);
    chk(si, 8'h1 << SI_LOW_FLT);
    @(posedge clk);
    pin1 <= 1'b0;
    step(2);
    chk(pg, 1'b0);
    @(posedge clk);
    pin1 <= 1'b1;
    clr;
    st(8'h00, 8'h00, 8'h00, 8'h00, 8'h00);
    // Overvoltage trip through the comparator front end.
    @(posedge clk);
    ov_level <= 4'hf;
    step(2);
    st(SB_OV, WH_FLT, LOWW, 8'h1 << SI_HIGH_FLT, PNG);
    chk({sw_on, alert_n}, 2'h0);
    chk(pg, 1'b0);
    @(posedge clk);
    ov_level <= 4'he;
    step(2);
    chk(sw_on, 1'b0);
    @(posedge clk);
    ov_level <= 4'h0;
    step(2);
    chk({sw_on, pg, alert_n}, 3'h6);
    chk(si, 8'h1 << SI_HIGH_FLT);
    clr;
    chk(alert_n, 1'b1);
    cmd(1'b1, CMD_IN_OV_FLT, 16'h0009);
    step(1);
    chk(dac, 4'h9);
    summarize;
  end
endmodule // testbench

// ---- src/stm_event_log.sv ----
// Small event-log memory with registered read data.
// Assumes writes arrive one word per cycle from the monitor.
`timescale 1ns/10ps
module stm_event_log #(
  parameter int AW = 3,
  parameter int DW = 13,
  parameter int DEPTH = 7
) (
  input logic clk,
  input logic reset_n,
  stm_log_if.mem lb
);
  import stm_pkg::*;

  typedef struct packed {
    logic [DEPTH-1:0][DW-1:0] mem;
    logic [DW-1:0] rd;
  } stm_log_st_t;

  stm_log_st_t st_ff;
  stm_log_st_t nxt_st;

  always_comb
  begin
    nxt_st = st_ff;
    if (lb.we && (int'(lb.waddr) < DEPTH))
    begin
      nxt_st.mem[lb.waddr] = lb.wdata;
    end
    nxt_st.rd = (int'(lb.raddr) < DEPTH) ? st_ff.mem[lb.raddr] : '0;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_ff <= '0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign lb.rdata = st_ff.rd;
endmodule // stm_event_log

// ---- src/stm_monitor.sv ----
// Supply threshold monitor: threshold registers, fault and warning flags,
// status bytes, alert, power-good and switch control, event logging.
// Assumes a word-level command port fed by the management bus front end,
// ADC telemetry and overvoltage comparator levels synchronous to clk.
`timescale 1ns/10ps
module stm_monitor #(
  parameter int TICK_CYCLES = stm_pkg::TICK_CYCLES_DEF
) (
  input logic clk,
  input logic reset_n,
  input logic cmd_valid,
  input logic cmd_write,
  input logic [7:0] cmd_code,
  input logic [15:0] cmd_wdata,
  output logic cmd_ack_ff,
  output logic [15:0] cmd_rdata_ff,
  input logic [7:0] vin_adc,
  input logic [7:0] vout_adc,
  input logic ov_above_rise,
  input logic ov_below_fall,
  output logic [3:0] in_ov_dac_code_ff,
  input logic clear_faults,
  input logic [2:0] alert_mask,
  input logic general_pin_four_is_alert,
  input logic general_pin_one_is_pg,
  input logic [stm_pkg::LOG_AW-1:0] log_rd_addr,
  output logic [stm_pkg::LOG_DW-1:0] log_rd_data_ff,
  output logic switch_on_ff,
  output logic power_good_pin_ff,
  output logic bus_alert_n_ff,
  output logic [7:0] status_byte_ff,
  output logic [7:0] status_word_hi_ff,
  output logic [7:0] status_vout_ff,
  output logic [7:0] status_input_ff,
  output logic [7:0] vendor_status_reg_two_ff,
  output logic [7:0] event_log_pointer_timer_ff
);
  import stm_pkg::*;

  localparam int DIV_W = $clog2(TICK_CYCLES);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(TICK_CYCLES - 1);
  localparam logic [8:0] HYST = 9'(HYST_CODES);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [15:0] thr_ouvw;
    logic [15:0] thr_iovf;
    logic [15:0] thr_iovw;
    logic [15:0] thr_iuvf;
    logic uv_live;
    logic ov_live;
    logic f_iuv;
    logic f_iov;
    logic w_iov;
    logic w_ouv;
    logic [2:0] ptr;
    logic full;
    logic exp;
    logic [3:0] tick;
    logic [DIV_W-1:0] div;
    logic ack;
    logic [15:0] rdata;
    logic [7:0] sb;
    logic [7:0] sw;
    logic [7:0] so;
    logic [7:0] si;
    logic [7:0] m2;
    logic sw_on;
    logic pg;
    logic alert_n;
  } stm_st_t;

  stm_st_t st_ff;
  stm_st_t nxt_st;

  stm_log_if #(.AW(LOG_AW), .DW(LOG_DW)) lb ();

  stm_event_log #(.AW(LOG_AW), .DW(LOG_DW), .DEPTH(LOG_DEPTH)) u_log (
    .clk(clk),
    .reset_n(reset_n),
    .lb(lb)
  );

  // A latched flag: the set wins over a clear, and a clear only takes
  // effect in a cycle where the condition behind the flag has gone away.
  function automatic logic flag_next(logic f, logic set, logic hold, logic clr);
    flag_next = set | (f & ~(clr & ~hold));
  endfunction

  logic uv_below;
  logic uv_above;
  logic iovw_cond;
  logic ouvw_cond;
  logic log_evt;
  logic any_fault;
  logic alert;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    nxt_st = st_ff;
    // Command port: one word per request, answered the next cycle.
    nxt_st.ack = cmd_valid;
    if (cmd_valid && cmd_write)
    begin
      case (cmd_code)
        CMD_OUT_UV_WARN: nxt_st.thr_ouvw = cmd_wdata;
        CMD_IN_OV_FLT: nxt_st.thr_iovf = cmd_wdata;
        CMD_IN_OV_WARN: nxt_st.thr_iovw = cmd_wdata;
        CMD_IN_UV_FLT: nxt_st.thr_iuvf = cmd_wdata;
        default: nxt_st.thr_iuvf = st_ff.thr_iuvf;
      endcase
    end
    if (cmd_valid && !cmd_write)
    begin
      case (cmd_code)
        CMD_OUT_UV_WARN: nxt_st.rdata = st_ff.thr_ouvw;
        CMD_IN_OV_FLT: nxt_st.rdata = st_ff.thr_iovf;
        CMD_IN_OV_WARN: nxt_st.rdata = st_ff.thr_iovw;
        CMD_IN_UV_FLT: nxt_st.rdata = st_ff.thr_iuvf;
        CMD_STATUS_WORD: nxt_st.rdata = {st_ff.sw, st_ff.sb};
        default: nxt_st.rdata = 16'h0000;
      endcase
    end

    // Thresholds are compared on their low bits; the upper bits are kept
    // only so that a read returns what was written.
    uv_below = vin_adc < st_ff.thr_iuvf[7:0];
    uv_above = {1'b0, vin_adc} > ({1'b0, st_ff.thr_iuvf[7:0]} + HYST);
    iovw_cond = vin_adc > st_ff.thr_iovw[7:0];
    ouvw_cond = vout_adc < st_ff.thr_ouvw[7:0];

    // ----------------------------------------
    // Switch control with hysteresis
    // ----------------------------------------
    if (uv_below)
    begin
      nxt_st.uv_live = 1'b1;
    end
    else if (uv_above)
    begin
      nxt_st.uv_live = 1'b0;
    end
    if (ov_above_rise)
    begin
      nxt_st.ov_live = 1'b1;
    end
    else if (ov_below_fall)
    begin
      nxt_st.ov_live = 1'b0;
    end
    nxt_st.sw_on = ~(nxt_st.uv_live | nxt_st.ov_live);

    // ----------------------------------------
    // Latched flags
    // ----------------------------------------
    nxt_st.f_iuv = flag_next(st_ff.f_iuv, uv_below, nxt_st.uv_live, clear_faults);
    nxt_st.f_iov = flag_next(st_ff.f_iov, ov_above_rise, nxt_st.ov_live, clear_faults);
    nxt_st.w_iov = flag_next(st_ff.w_iov, iovw_cond, iovw_cond, clear_faults);
    nxt_st.w_ouv = flag_next(st_ff.w_ouv, ouvw_cond, ouvw_cond, clear_faults);

    // ----------------------------------------
    // Event log pointer and tick timer
    // ----------------------------------------
    if (st_ff.div == DIV_LAST)
    begin
      nxt_st.div = '0;
      nxt_st.tick = st_ff.tick + 4'h1;
      if (st_ff.tick == 4'hf)
      begin
        nxt_st.exp = 1'b1;
      end
    end
    else
    begin
      nxt_st.div = st_ff.div + DIV_W'(1);
    end
    if (clear_faults)
    begin
      nxt_st.ptr = 3'h0;
      nxt_st.full = 1'b0;
      nxt_st.exp = 1'b0;
      nxt_st.tick = 4'h0;
      nxt_st.div = '0;
    end
    // A new warning is logged even in a clear cycle, after the clear.
    log_evt = iovw_cond & ~st_ff.w_iov & ~nxt_st.full;
    if (iovw_cond && !st_ff.w_iov)
    begin
      nxt_st.tick = 4'h0;
      nxt_st.exp = 1'b0;
      nxt_st.div = '0;
    end
    if (log_evt)
    begin
      if (nxt_st.ptr < LOG_LAST_PTR)
      begin
        nxt_st.ptr = nxt_st.ptr + 3'h1;
      end
      else
      begin
        nxt_st.ptr = 3'h0;
        nxt_st.full = 1'b1;
      end
    end

    // ----------------------------------------
    // Status bytes from the next flags
    // ----------------------------------------
    any_fault = nxt_st.f_iuv | nxt_st.f_iov;
    nxt_st.sb = 8'h00;
    nxt_st.sw = 8'h00;
    nxt_st.so = 8'h00;
    nxt_st.si = 8'h00;
    nxt_st.m2 = 8'h00;
    nxt_st.sb[SB_SWITCH_OFF] = any_fault;
    nxt_st.sb[SB_IN_LOW] = nxt_st.f_iuv;
    nxt_st.sb[SB_OTHER] = any_fault | nxt_st.w_iov | nxt_st.w_ouv;
    nxt_st.sw[SW_OUT] = any_fault | nxt_st.w_ouv;
    nxt_st.sw[SW_IN] = any_fault | nxt_st.w_iov;
    nxt_st.sw[SW_PNG] = any_fault;
    nxt_st.sw[SW_OTHER] = any_fault;
    nxt_st.so[SO_LOW_WARN] = any_fault | nxt_st.w_ouv;
    nxt_st.si[SI_HIGH_FLT] = nxt_st.f_iov;
    nxt_st.si[SI_HIGH_WARN] = nxt_st.w_iov;
    nxt_st.si[SI_LOW_FLT] = nxt_st.f_iuv;
    nxt_st.m2[M2_PNG] = any_fault;

    // ----------------------------------------
    // Alert and power good
    // ----------------------------------------
    // A fault touches three alert groups, so it needs all of them open.
    alert = (any_fault & ~|alert_mask)
          | (nxt_st.w_iov & ~alert_mask[MASK_IN])
          | (nxt_st.w_ouv & ~alert_mask[MASK_OUT]);
    nxt_st.alert_n = ~(alert & general_pin_four_is_alert);
    nxt_st.pg = general_pin_one_is_pg & nxt_st.sw_on;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      st_ff <= '0;
      st_ff.thr_ouvw <= RST_OUT_UV_WARN;
      st_ff.thr_iovf <= RST_IN_OV_FLT;
      st_ff.thr_iovw <= RST_IN_OV_WARN;
      st_ff.thr_iuvf <= RST_IN_UV_FLT;
      st_ff.alert_n <= 1'b1;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign lb.we = log_evt;
  assign lb.waddr = st_ff.ptr;
  assign lb.wdata = {EVT_IN_HIGH_WARN, st_ff.exp, st_ff.tick};
  assign lb.raddr = log_rd_addr;
  assign log_rd_data_ff = lb.rdata;
  assign cmd_ack_ff = st_ff.ack;
  assign cmd_rdata_ff = st_ff.rdata;
  assign in_ov_dac_code_ff = st_ff.thr_iovf[3:0];
  assign switch_on_ff = st_ff.sw_on;
  assign power_good_pin_ff = st_ff.pg;
  assign bus_alert_n_ff = st_ff.alert_n;
  assign status_byte_ff = st_ff.sb;
  assign status_word_hi_ff = st_ff.sw;
  assign status_vout_ff = st_ff.so;
  assign status_input_ff = st_ff.si;
  assign vendor_status_reg_two_ff = st_ff.m2;
  assign event_log_pointer_timer_ff = {st_ff.ptr, st_ff.exp, st_ff.tick};

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  property p_uv_status;
    st_ff.f_iuv |-> status_byte_ff[SB_SWITCH_OFF] && status_byte_ff[SB_IN_LOW]
      && status_word_hi_ff[SW_PNG] && status_word_hi_ff[SW_IN] && status_word_hi_ff[SW_OUT];
  endproperty
  a_uv_status: assert property (p_uv_status) else $error("low fault status missing");

  property p_uv_sub;
    st_ff.f_iuv |-> status_vout_ff[SO_LOW_WARN] && status_input_ff[SI_LOW_FLT]
      && vendor_status_reg_two_ff[M2_PNG];
  endproperty
  a_uv_sub: assert property (p_uv_sub) else $error("low fault sub status missing");

  property p_alert_cfg;
    !bus_alert_n_ff |-> $past(general_pin_four_is_alert);
  endproperty
  a_alert_cfg: assert property (p_alert_cfg) else $error("alert without pin four");

  property p_pg_fault;
    (st_ff.uv_live || st_ff.ov_live) |-> !power_good_pin_ff && !switch_on_ff;
  endproperty
  a_pg_fault: assert property (p_pg_fault) else $error("power good during fault");

  property p_word_rw;
    (cmd_valid && cmd_write && cmd_code == CMD_IN_OV_WARN)
      ##1 (cmd_valid && !cmd_write && cmd_code == CMD_IN_OV_WARN)
      |=> cmd_ack_ff && cmd_rdata_ff == $past(cmd_wdata, 2);
  endproperty
  a_word_rw: assert property (p_word_rw) else $error("threshold readback wrong");

  property p_warn_set;
    (vin_adc > st_ff.thr_iovw[7:0]) |=> st_ff.w_iov && status_input_ff[SI_HIGH_WARN];
  endproperty
  a_warn_set: assert property (p_warn_set) else $error("high warning not set");

  property p_warn_clr;
    $fell(st_ff.w_iov) |-> $past(clear_faults);
  endproperty
  a_warn_clr: assert property (p_warn_clr) else $error("warning cleared on its own");

  property p_ptr_step;
    (lb.we && st_ff.ptr < LOG_LAST_PTR && !clear_faults) |=> st_ff.ptr == $past(st_ff.ptr) + 3'h1;
  endproperty
  a_ptr_step: assert property (p_ptr_step) else $error("log pointer step wrong");

  property p_ov_off;
    ov_above_rise |=> !switch_on_ff ##1 status_byte_ff[SB_SWITCH_OFF];
  endproperty
  a_ov_off: assert property (p_ov_off) else $error("switch stayed on");

  property p_out_warn;
    (vout_adc < st_ff.thr_ouvw[7:0]) |=> status_word_hi_ff[SW_OUT] && status_vout_ff[SO_LOW_WARN];
  endproperty
  a_out_warn: assert property (p_out_warn) else $error("output warning status missing");
endmodule // stm_monitor
